/* hdl/tcsrf_top.sv */
// Functional notes
// - Notch frequency accepted only from 50 to 1000 Hz; notch sits there.
// - Notch depth zero bypasses the notch whatever the centre frequency.
// - Notch depth accepted from 0 to 32 dB at the centre frequency.
// - Low-pass time constant accepted 0..1000 ms; zero means pass-through.
// - Larger low-pass time constant gives a lower cutoff.
// - After reset load 2 ms low-pass, or 5 ms for units above 1 kW.
// - Code 00 gives mode default; 01, 10, 11 give presets one to three.
// - Code 00 forces zero in zero-default mode, analog in analog mode.
// - Analog reference spans -10 V to +10 V, scaled by maximum torque.
// - Preset commands are limited to plus or minus 300 percent.
// - A new preset takes effect only after a select input changes.
// - Select input low (open) decodes 0, high (closed) decodes 1.
// - Position and speed modes output a limit; torque modes a command.
// - Mode setting with select inputs chooses analog or zero default.
// - Current-loop gain is fixed and cannot be written.
// - Analog torque percent equals volts times maximum torque over ten.
// - Smoothing time constant zero passes the command unfiltered.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module tcsrf_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic torque_select_bit0_in,
  input wire logic torque_select_bit1_in,
  input wire logic rated_above_1kw_in,
  input wire logic signed [15:0] analog_ref_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic signed [15:0] torque_cmd_out,
  output logic signed [15:0] torque_limit_out,
  output logic torque_mode_out
);
  import tcsrf_pkg::*;

  if (ADDR_W < IDX_W + 2 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 12 and 32");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic s0_m;
    logic s0;
    logic s1_m;
    logic s1;
    logic st_m;
    logic st;
    logic [1:0] init;
    logic [11:0] cnt;
    logic [1:0] code;
    logic signed [15:0] pre_act;
    logic [15:0] freq;
    logic [15:0] depth;
    logic [15:0] lptc;
    logic [15:0] mts;
    logic [15:0] tsc;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [15:0] p3;
    tcsrf_mode_e mode;
    logic [16:0] lp_c;
    logic [16:0] sm_c;
    logic [18:0] nb;
    logic [18:0] na;
    logic [15:0] att;
    logic signed [15:0] sm_y;
    logic signed [15:0] lp_y;
    logic signed [15:0] x1;
    logic signed [15:0] x2;
    logic signed [19:0] n1;
    logic signed [19:0] n2;
    logic signed [15:0] out;
    logic signed [15:0] cmd;
    logic signed [15:0] lim;
    logic tmode;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic aw_h;
    logic w_h;
    logic aw_ok;
    logic [9:0] aw_i;
    logic [31:0] wd;
    logic [3:0] ws;
    logic arr;
    logic rv;
    logic [1:0] rr;
    logic [31:0] rd;
  } tcsrf_state_s;

  tcsrf_state_s s_q;
  tcsrf_state_s s_d;
  logic tick;
  logic signed [15:0] x_sel;
  logic signed [15:0] sm_new;
  logic signed [15:0] lp_new;

  // ------------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------------
  function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sh7FFF) sat16 = 16'sh7FFF;
    else if (v < -64'sh8000) sat16 = 16'sh8000;
    else sat16 = v[15:0];
  endfunction

  // Coefficient is sample period over tau, so it falls as tau rises
  function automatic logic [16:0] lp_coef(input logic [15:0] t);
    if (t == 16'h0000) lp_coef = 17'h00000;
    else lp_coef = 17'(LP_NUM / int'(t));
  endfunction

  // First order step, coefficient in Q16
  function automatic logic signed [15:0] lp_step(
      input logic signed [15:0] y, input logic signed [15:0] x,
      input logic [16:0] c);
    logic signed [63:0] p;
    p = (64'(x) - 64'(y)) * $signed(64'(c));
    lp_step = sat16(64'(y) + (p >>> 16));
  endfunction

  // Twice cos(2 pi f Ts) in Q16 by a fourth order series
  function automatic logic [18:0] cos2(input logic [15:0] f);
    logic [47:0] a;
    logic [47:0] q;
    a = (48'(f) * 48'(f) * 48'(COS_K)) >> 20;
    q = (((a * a) >> 16) * 48'(SIXTH)) >> 16;
    cos2 = 19'((48'h10000 - a + q) << 1);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o,
      input logic [31:0] d, input logic [3:0] b);
    merge = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
  endfunction

  // Read mux; bit 32 flags a mapped index
  function automatic logic [32:0] rdreg(input tcsrf_state_s s,
      input logic [9:0] i);
    rdreg = {1'b1, 32'h0000_0000};
    case (i)
      REG_NOTCH_CENTER_FREQUENCY: rdreg[15:0] = s.freq;
      REG_NOTCH_ATTENUATION_DEPTH: rdreg[15:0] = s.depth;
      REG_LOWPASS_TIME_CONSTANT: rdreg[15:0] = s.lptc;
      REG_TORQUE_PRESET_1: rdreg[15:0] = s.p1;
      REG_TORQUE_PRESET_2: rdreg[15:0] = s.p2;
      REG_TORQUE_PRESET_3: rdreg[15:0] = s.p3;
      REG_MAX_TORQUE_SCALE: rdreg[15:0] = s.mts;
      REG_CONTROL_MODE_SELECT: rdreg[1:0] = s.mode;
      REG_TORQUE_SMOOTH_CONST: rdreg[15:0] = s.tsc;
      REG_STATUS: rdreg[31:0] = {s.out, 11'h000, s.st, s.mode, s.code};
      REG_CURRENT_GAIN: rdreg[15:0] = CURRENT_GAIN_FIXED;
      default: rdreg[32] = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [32:0] rv_w;
    logic [15:0] v;
    logic ok;
    logic tm;
    logic signed [15:0] ana;
    logic signed [63:0] num;
    logic signed [63:0] acc;
    logic signed [19:0] nn;
    logic signed [63:0] g;
    logic signed [15:0] outv;
    s_d = s_q;
    rv_w = 33'h0_0000_0000;
    v = 16'h0000;
    ok = 1'b0;
    tm = s_q.mode[1];
    ana = 16'sh0000;
    num = 64'sh0;
    acc = 64'sh0;
    nn = 20'sh00000;
    g = 64'sh0;
    outv = 16'sh0000;
    // Pins pass two flops; closed contact drives high and reads 1
    s_d.s0_m = torque_select_bit0_in;
    s_d.s0 = s_q.s0_m;
    s_d.s1_m = torque_select_bit1_in;
    s_d.s1 = s_q.s1_m;
    s_d.st_m = rated_above_1kw_in;
    s_d.st = s_q.st_m;
    // Strap is sampled once it has crossed both flops
    if (s_q.init != 2'h3) s_d.init = s_q.init + 2'h1;
    if (s_q.init == 2'h2) begin
      s_d.lptc = s_q.st ? RST_LP_LARGE : RST_LP_SMALL;
      s_d.lp_c = lp_coef(s_d.lptc);
      s_d.sm_c = lp_coef(s_q.tsc);
      s_d.nb = cos2(s_q.freq);
      s_d.na = 19'((64'(cos2(s_q.freq)) * 64'(NOTCH_B0)) >> 16);
      s_d.att = ATTEN[s_q.depth[5:0]];
    end
    // Preset latches only on a select edge, so register edits wait
    if ({s_q.s1, s_q.s0} != s_q.code) begin
      s_d.code = {s_q.s1, s_q.s0};
      unique case ({s_q.s1, s_q.s0})
        2'b00: s_d.pre_act = 16'sh0000;
        2'b01: s_d.pre_act = 16'($signed(s_q.p1) * 16'sh000A);
        2'b10: s_d.pre_act = 16'($signed(s_q.p2) * 16'sh000A);
        2'b11: s_d.pre_act = 16'($signed(s_q.p3) * 16'sh000A);
      endcase
    end
    // Analog 0.1 percent = ref * scale * 10 / full scale
    ana = sat16((64'(analog_ref_in) * $signed(64'(s_q.mts)) * 64'sh0A)
                >>> 15);
    if (s_q.code != 2'b00) x_sel = s_q.pre_act;
    else if (s_q.mode == TCSRF_MODE_TORQUE_ZERO) x_sel = 16'sh0000;
    else x_sel = ana;
    // Smoothing only in torque modes; zero bypasses
    if (tm && s_q.tsc != 16'h0000) sm_new = lp_step(s_q.sm_y, x_sel, s_q.sm_c);
    else sm_new = x_sel;
    if (s_q.lptc != 16'h0000) lp_new = lp_step(s_q.lp_y, sm_new, s_q.lp_c);
    else lp_new = sm_new;
    // Unity-DC notch, pole radius fixed; depth blends it with input
    num = (64'(lp_new) <<< 16) - $signed(64'(s_q.nb)) * 64'(s_q.x1)
        + (64'(s_q.x2) <<< 16);
    num = (num * 64'(NOTCH_B0)) >>> 16;
    acc = num + $signed(64'(s_q.na)) * 64'(s_q.n1)
        - 64'(NOTCH_A2) * 64'(s_q.n2);
    nn = 20'(acc >>> 16);
    g = 64'sh10000 - $signed(64'(s_q.att));
    if (s_q.depth == 16'h0000) outv = lp_new;
    else outv = sat16(64'(lp_new)
        - ((g * (64'(lp_new) - 64'(nn))) >>> 16));
    // Sample divider; every stage advances on the same tick
    tick = (s_q.init == 2'h3) && (s_q.cnt == 12'(TICK_CYC - 1));
    s_d.cnt = (s_q.cnt == 12'(TICK_CYC - 1)) ? 12'h000 : s_q.cnt + 12'h001;
    if (tick) begin
      s_d.sm_y = sm_new;
      s_d.lp_y = lp_new;
      s_d.x1 = lp_new;
      s_d.x2 = s_q.x1;
      s_d.n1 = nn;
      s_d.n2 = s_q.n1;
      s_d.out = outv;
      s_d.cmd = tm ? outv : 16'sh0000;
      s_d.lim = tm ? 16'sh0000 : outv;
      s_d.tmode = tm;
    end
    // Write address and data are taken in either order
    if (s_axi_awvalid_in && s_q.awr) begin
      s_d.aw_h = 1'b1;
      s_d.aw_i = s_axi_awaddr_in[IDX_W+1:2];
      s_d.aw_ok = ~|(s_axi_awaddr_in >> (IDX_W + 2));
    end
    if (s_axi_wvalid_in && s_q.wr) begin
      s_d.w_h = 1'b1;
      s_d.wd = s_axi_wdata_in;
      s_d.ws = s_axi_wstrb_in;
    end
    // Out-of-range values are dropped and answered with SLVERR
    if (s_q.aw_h && s_q.w_h && !s_q.bv) begin
      rv_w = rdreg(s_q, s_q.aw_i);
      v = merge(rv_w[15:0], s_q.wd, s_q.ws);
      ok = 1'b0;
      if (s_q.aw_ok) begin
        case (s_q.aw_i)
          REG_NOTCH_CENTER_FREQUENCY: begin
            ok = (v >= FREQ_MIN) && (v <= FREQ_MAX);
            if (ok) begin
              s_d.freq = v;
              s_d.nb = cos2(v);
              s_d.na = 19'((64'(cos2(v)) * 64'(NOTCH_B0)) >> 16);
            end
          end
          REG_NOTCH_ATTENUATION_DEPTH: begin
            ok = v <= DEPTH_MAX;
            if (ok) begin
              s_d.depth = v;
              s_d.att = ATTEN[v[5:0]];
            end
          end
          REG_LOWPASS_TIME_CONSTANT: begin
            ok = v <= TC_MAX;
            if (ok) begin
              s_d.lptc = v;
              s_d.lp_c = lp_coef(v);
            end
          end
          REG_TORQUE_PRESET_1, REG_TORQUE_PRESET_2, REG_TORQUE_PRESET_3: begin
            ok = ($signed(v) <= PRESET_LIM)
                && ($signed(v) >= -PRESET_LIM);
            if (ok && s_q.aw_i == REG_TORQUE_PRESET_1) s_d.p1 = v;
            if (ok && s_q.aw_i == REG_TORQUE_PRESET_2) s_d.p2 = v;
            if (ok && s_q.aw_i == REG_TORQUE_PRESET_3) s_d.p3 = v;
          end
          REG_MAX_TORQUE_SCALE: begin
            ok = v <= TC_MAX;
            if (ok) s_d.mts = v;
          end
          REG_CONTROL_MODE_SELECT: begin
            ok = v[15:2] == 14'h0000;
            if (ok) s_d.mode = tcsrf_mode_e'(v[1:0]);
          end
          REG_TORQUE_SMOOTH_CONST: begin
            ok = v <= TC_MAX;
            if (ok) begin
              s_d.tsc = v;
              s_d.sm_c = lp_coef(v);
            end
          end
          default: ok = 1'b0;
        endcase
      end
      s_d.aw_h = 1'b0;
      s_d.w_h = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bv && s_axi_bready_in) s_d.bv = 1'b0;
    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid_in && s_q.arr) begin
      rv_w = rdreg(s_q, s_axi_araddr_in[IDX_W+1:2]);
      ok = rv_w[32] && ~|(s_axi_araddr_in >> (IDX_W + 2));
      s_d.rv = 1'b1;
      s_d.rd = ok ? rv_w[31:0] : 32'h0000_0000;
      s_d.rr = ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rv && s_axi_rready_in) s_d.rv = 1'b0;
    s_d.awr = (s_q.init == 2'h3) && !s_d.aw_h && !s_d.bv;
    s_d.wr = (s_q.init == 2'h3) && !s_d.w_h && !s_d.bv;
    s_d.arr = (s_q.init == 2'h3) && !s_d.rv;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
      s_q.freq <= RST_NOTCH_FREQ;
      s_q.depth <= RST_NOTCH_DEPTH;
      s_q.p1 <= RST_PRESET;
      s_q.p2 <= RST_PRESET;
      s_q.p3 <= RST_PRESET;
      s_q.mts <= RST_MAX_SCALE;
      s_q.tsc <= RST_SMOOTH;
      s_q.mode <= RST_MODE;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register
  assign s_axi_awready_out = s_q.awr;
  assign s_axi_wready_out = s_q.wr;
  assign s_axi_bvalid_out = s_q.bv;
  assign s_axi_bresp_out = s_q.br;
  assign s_axi_arready_out = s_q.arr;
  assign s_axi_rvalid_out = s_q.rv;
  assign s_axi_rdata_out = s_q.rd;
  assign s_axi_rresp_out = s_q.rr;
  assign torque_cmd_out = s_q.cmd;
  assign torque_limit_out = s_q.lim;
  assign torque_mode_out = s_q.tmode;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_FREQ_RANGE: assert property (
    s_q.freq >= FREQ_MIN && s_q.freq <= FREQ_MAX)
    else $error("notch frequency out of range");
  AST_NOTCH_BYPASS: assert property (
    tick && s_q.depth == 16'h0000 |=> s_q.out == s_q.lp_y)
    else $error("zero depth did not bypass notch");
  AST_DEPTH_RANGE: assert property (
    s_q.depth <= DEPTH_MAX && (s_q.depth == 16'h0000
      || s_q.init != 2'h3 || s_q.att == ATTEN[s_q.depth[5:0]]))
    else $error("notch depth or gain mismatch");
  AST_LP_BYPASS: assert property (
    tick && s_q.lptc == 16'h0000 |=> s_q.lp_y == s_q.sm_y)
    else $error("zero time constant did not pass through");
  AST_LP_MONO: assert property (
    s_q.init == 2'h3 && $past(s_q.lptc) != 16'h0000
      && s_q.lptc > $past(s_q.lptc) |-> s_q.lp_c <= $past(s_q.lp_c))
    else $error("cutoff rose with time constant");
  AST_LP_DEFAULT: assert property (
    $rose(s_q.init == 2'h3)
      |-> s_q.lptc == (s_q.st ? RST_LP_LARGE : RST_LP_SMALL))
    else $error("wrong low-pass default");
  AST_CODE_FOLLOWS: assert property (
    $changed({torque_select_bit1_in, torque_select_bit0_in})
      ##1 $stable({torque_select_bit1_in, torque_select_bit0_in}) [*3]
      |-> s_q.code == $past({torque_select_bit1_in,
                             torque_select_bit0_in}, 1))
    else $error("select code not latched from pins");
  AST_ZERO_MODE: assert property (
    s_q.code == 2'b00 && s_q.mode == TCSRF_MODE_TORQUE_ZERO
      |-> x_sel == 16'sh0000)
    else $error("zero-default mode not zero");
  AST_PRESET_LIM: assert property (
    $signed(s_q.pre_act) <= 16'sh0BB8 && $signed(s_q.pre_act) >= -16'sh0BB8)
    else $error("active preset beyond 300 percent");
  AST_SMOOTH_BYPASS: assert property (
    tick && s_q.tsc == 16'h0000 |=> s_q.sm_y == $past(x_sel))
    else $error("smoothing not bypassed");
  AST_ROUTE: assert property (
    tick ##1 1'b1 |-> (s_q.tmode ? (torque_limit_out == 16'sh0000
      && torque_cmd_out == s_q.out) : (torque_cmd_out == 16'sh0000
      && torque_limit_out == s_q.out)))
    else $error("command routed to wrong output");
  AST_BRESP: assert property (
    s_q.aw_h && s_q.w_h && !s_q.bv && s_q.aw_i == REG_CURRENT_GAIN
      |=> s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR)
    else $error("gain register accepted a write");

  COV_CODE: cover property ($changed(s_q.code) && s_q.code != 2'b00);
  COV_NOTCH: cover property (tick && s_q.depth != 16'h0000);
  COV_WRITE: cover property (s_axi_bvalid_out && s_axi_bready_in);
  COV_READ: cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule // tcsrf_top

/* hdl/tcsrf_pkg.sv */
package tcsrf_pkg;
  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int IDX_W = 10;
  localparam logic [9:0] REG_NOTCH_CENTER_FREQUENCY = 10'h217;
  localparam logic [9:0] REG_NOTCH_ATTENUATION_DEPTH = 10'h218;
  localparam logic [9:0] REG_LOWPASS_TIME_CONSTANT = 10'h219;
  localparam logic [9:0] REG_TORQUE_PRESET_1 = 10'h300;
  localparam logic [9:0] REG_TORQUE_PRESET_2 = 10'h301;
  localparam logic [9:0] REG_TORQUE_PRESET_3 = 10'h302;
  localparam logic [9:0] REG_MAX_TORQUE_SCALE = 10'h303;
  localparam logic [9:0] REG_CONTROL_MODE_SELECT = 10'h304;
  localparam logic [9:0] REG_TORQUE_SMOOTH_CONST = 10'h305;
  localparam logic [9:0] REG_STATUS = 10'h306;
  localparam logic [9:0] REG_CURRENT_GAIN = 10'h307;
  // ------------------------------------------------------------------
  // Reset values and accepted ranges
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_NOTCH_FREQ = 16'h03E8;
  localparam logic [15:0] RST_NOTCH_DEPTH = 16'h0000;
  localparam logic [15:0] RST_LP_SMALL = 16'h0002;
  localparam logic [15:0] RST_LP_LARGE = 16'h0005;
  localparam logic [15:0] RST_PRESET = 16'h0000;
  localparam logic [15:0] RST_MAX_SCALE = 16'h0064;
  localparam logic [15:0] RST_SMOOTH = 16'h0000;
  localparam logic [15:0] FREQ_MIN = 16'h0032;
  localparam logic [15:0] FREQ_MAX = 16'h03E8;
  localparam logic [15:0] DEPTH_MAX = 16'h0020;
  localparam logic [15:0] TC_MAX = 16'h03E8;
  localparam logic signed [15:0] PRESET_LIM = 16'sh012C;
  // Arbitrary value, fixed current-loop gain word
  localparam logic [15:0] CURRENT_GAIN_FIXED = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // Modes, timing and filter constants
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCSRF_MODE_POSITION = 2'b00,
    TCSRF_MODE_SPEED = 2'b01,
    TCSRF_MODE_TORQUE = 2'b10,
    TCSRF_MODE_TORQUE_ZERO = 2'b11
  } tcsrf_mode_e;
  localparam tcsrf_mode_e RST_MODE = TCSRF_MODE_TORQUE;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_US = 100;
  localparam int TICK_CYC = SAMPLE_US * 1000 / CLK_PERIOD_NS;
  localparam int LP_NUM = SAMPLE_US * 65536 / 1000;
  localparam int COS_K = 13566;
  localparam int SIXTH = 10923;
  localparam int NOTCH_B0 = 62259;
  localparam int NOTCH_A2 = 58982;
  // Residual gain per dB of depth, Q16 (entry 0 unused: bypass)
  localparam logic [15:0] ATTEN [33] = '{
    16'hFFFF, 16'hE429, 16'hCB59, 16'hB53C, 16'hA186, 16'h8FF6, 16'h804E,
    16'h725A, 16'h65EA, 16'h5AD5, 16'h50F4, 16'h4827, 16'h404E, 16'h3950,
    16'h3314, 16'h2D86, 16'h2893, 16'h2429, 16'h203A, 16'h1CB9, 16'h199A,
    16'h16D1, 16'h1456, 16'h1220, 16'h1027, 16'h0E65, 16'h0CD5, 16'h0B6F,
    16'h0A31, 16'h0915, 16'h0818, 16'h0737, 16'h066E};
endpackage

/* verification/tcsrf_host_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host controller: contact pins and analog reference word
// ------------------------------------------------------------
module tcsrf_host_model (
  input wire logic clk_in,
  output logic sel0_out,
  output logic sel1_out,
  output logic signed [15:0] ref_out
);
  // Contacts open and reference at 0 V until the host acts
  initial begin
    sel0_out = 1'b0;
    sel1_out = 1'b0;
    ref_out = 16'sh0000;
  end
  // Closed contact drives high, both pins move on one edge
  task automatic set_code(input logic [1:0] c);
    @(posedge clk_in);
    sel0_out <= c[0];
    sel1_out <= c[1];
  endtask
  // Reference word, full scale is +/-10 V
  task automatic set_ref(input logic signed [15:0] v);
    @(posedge clk_in);
    ref_out <= v;
  endtask
endmodule // tcsrf_host_model

/* verification/torque_cmd_select_resonance_filter_tb_top.sv */
`timescale 1ns/10ps
module torque_cmd_select_resonance_filter_tb_top;
  import tcsrf_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [11:0] aw = 12'h000;
  logic [11:0] ar = 12'h000;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, sel0, sel1, tmode;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic strap = 1'b0;
  logic signed [15:0] aref, tcmd, tlim;
  int n_errors = 0;
  int total_checks = 0;

  // Clock at 40 MHz
  always #12.5 clk_in = ~clk_in;

  tcsrf_host_model host (.clk_in(clk_in), .sel0_out(sel0),
    .sel1_out(sel1), .ref_out(aref));

  // Strap low until the second reset: small unit first, large unit after
  tcsrf_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .torque_select_bit0_in(sel0), .torque_select_bit1_in(sel1),
    .rated_above_1kw_in(strap), .analog_ref_in(aref),
    .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rry), .torque_cmd_out(tcmd),
    .torque_limit_out(tlim), .torque_mode_out(tmode));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] i, input logic [15:0] v,
      input logic [1:0] e);
    @(posedge clk_in);
    aw <= {i, 2'b00};
    awv <= 1'b1;
    wd <= {16'h0000, v};
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] d,
      input logic [1:0] e);
    @(posedge clk_in);
    ar <= {i, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    chk(rdata, d);
    chk({30'h0, rresp}, {30'h0, e});
  endtask
  // Two full sample periods so a change reaches the outputs
  task automatic ticks;
    repeat (2 * TICK_CYC + 100) @(posedge clk_in);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(REG_NOTCH_CENTER_FREQUENCY, 32'h3E8, RESP_OKAY);
    rd(REG_NOTCH_ATTENUATION_DEPTH, 32'h0, RESP_OKAY);
    rd(REG_LOWPASS_TIME_CONSTANT, 32'h2, RESP_OKAY);
    rd(REG_CURRENT_GAIN, 32'h100, RESP_OKAY);
    wr(REG_CURRENT_GAIN, 16'h0200, RESP_SLVERR);
    rd(REG_CURRENT_GAIN, 32'h100, RESP_OKAY);
    rd(10'h3FF, 32'h0, RESP_SLVERR);
  endtask
  // Range edges: one below, one above, then the limit itself
  task automatic t_range;
    wr(REG_NOTCH_CENTER_FREQUENCY, 16'h0031, RESP_SLVERR);
    wr(REG_NOTCH_CENTER_FREQUENCY, 16'h03E9, RESP_SLVERR);
    wr(REG_NOTCH_CENTER_FREQUENCY, 16'h0032, RESP_OKAY);
    rd(REG_NOTCH_CENTER_FREQUENCY, 32'h32, RESP_OKAY);
    wr(REG_NOTCH_ATTENUATION_DEPTH, 16'h0021, RESP_SLVERR);
    wr(REG_NOTCH_ATTENUATION_DEPTH, 16'h0020, RESP_OKAY);
    wr(REG_NOTCH_ATTENUATION_DEPTH, 16'h0000, RESP_OKAY);
    wr(REG_LOWPASS_TIME_CONSTANT, 16'h03E9, RESP_SLVERR);
    wr(REG_LOWPASS_TIME_CONSTANT, 16'h0000, RESP_OKAY);
  endtask
  // Filters bypassed, so presets reach the output unchanged
  task automatic t_sel;
    logic [15:0] exp [4];
    exp = '{16'h0000, 16'h0BB8, 16'hF448, 16'h04CE};
    wr(REG_CONTROL_MODE_SELECT, 16'h0003, RESP_OKAY);
    wr(REG_TORQUE_PRESET_1, 16'h012C, RESP_OKAY);
    wr(REG_TORQUE_PRESET_2, 16'hFED4, RESP_OKAY);
    wr(REG_TORQUE_PRESET_3, 16'h007B, RESP_OKAY);
    wr(REG_TORQUE_PRESET_1, 16'h012D, RESP_SLVERR);
    rd(REG_TORQUE_PRESET_2, 32'hFED4, RESP_OKAY);
    for (int c = 1; c < 4; c++) begin
      host.set_code(c[1:0]);
      ticks();
      chk({16'h0, tcmd}, {16'h0, exp[c]});
    end
    // Preset rewritten while the pins hold still: no effect yet
    wr(REG_TORQUE_PRESET_3, 16'h0032, RESP_OKAY);
    ticks();
    chk({16'h0, tcmd}, 32'h04CE);
    host.set_code(2'b00);
    ticks();
    chk({16'h0, tcmd}, 32'h0000);
    chk({31'h0, tmode}, 32'h1);
    rd(REG_STATUS, 32'h0000_000C, RESP_OKAY);
  endtask
  // Half scale at 100 percent gives 50.0 percent
  task automatic t_ana;
    host.set_ref(16'sh4000);
    wr(REG_CONTROL_MODE_SELECT, 16'h0002, RESP_OKAY);
    ticks();
    chk({16'h0, tcmd}, 32'h01F4);
    wr(REG_CONTROL_MODE_SELECT, 16'h0000, RESP_OKAY);
    ticks();
    chk({16'h0, tlim}, 32'h01F4);
    chk({16'h0, tcmd}, 32'h0000);
    chk({31'h0, tmode}, 32'h0);
    wr(REG_CONTROL_MODE_SELECT, 16'h0001, RESP_OKAY);
    ticks();
    chk({16'h0, tlim}, 32'h01F4);
    chk({16'h0, tcmd}, 32'h0000);
  endtask
  // Longest time constant: the step cannot settle in two samples
  task automatic t_lp;
    wr(REG_LOWPASS_TIME_CONSTANT, 16'h0002, RESP_OKAY);
    wr(REG_LOWPASS_TIME_CONSTANT, 16'h03E8, RESP_OKAY);
    wr(REG_CONTROL_MODE_SELECT, 16'h0002, RESP_OKAY);
    host.set_ref(16'sh7FFF);
    ticks();
    chk({31'h0, tcmd < 16'sd999}, 32'h1);
  endtask

  // Second reset with the strap high: larger unit default
  task automatic t_strap;
    strap <= 1'b1;
    reset_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    rd(REG_LOWPASS_TIME_CONSTANT, 32'h5, RESP_OKAY);
    rd(REG_NOTCH_CENTER_FREQUENCY, 32'h3E8, RESP_OKAY);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    t_regs();
    t_range();
    t_sel();
    t_ana();
    t_lp();
    t_strap();
    end_sim();
  end
  // Watchdog sized above the roughly 73000 cycles of the run
  initial begin
    repeat (100000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end
endmodule // torque_cmd_select_resonance_filter_tb_top
